//--- src/lsc_regs.svh
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
// ==========================================
// Register indices (byte address is index times four)
`define LSC_IDX_SUBSYS_EN 12'h200
`define LSC_IDX_SYNC_REQ 12'h203
`define LSC_IDX_LINK_CONTROL 12'h204
`define LSC_IDX_LINK_TEST_SELECT 12'h205
`define LSC_IDX_LINK_AUX 12'h20E
`define LSC_IDX_LINK_STATUS 12'h20F
// ==========================================
// Reset values
`define LSC_RST_SUBSYS_EN 1'h1
`define LSC_RST_SYNC_REQ 1'h1
`define LSC_RST_LINK_CONTROL 8'h03
`define LSC_RST_LINK_TEST_SELECT 8'h00
`define LSC_RST_LINK_AUX 2'h0
// ==========================================
// Field positions
`define LSC_CTRL_WHITEN 0
`define LSC_CTRL_FORMAT 1
`define LSC_CTRL_SYNC_LO 2
`define LSC_CTRL_SYNC_HI 3
`define LSC_CTRL_UPPER 4
`define LSC_TEST_HI 4
`define LSC_AUX_ENC64 0
`define LSC_AUX_TS_RX_EN 1
`define LSC_UPPER_BASE 4
// ==========================================
// Characters and patterns
`define LSC_CHAR_D21_5 8'hB5
`define LSC_CHAR_K28_5 8'hBC
`define LSC_CHAR_K28_7 8'hFC
`define LSC_CHAR_K28_0 8'h1C
`define LSC_CHAR_K28_3 8'h7C
`define LSC_CLOCK_WORD 16'h00FF
`define LSC_ILA_LAST 2'h3
`define LSC_RPAT_LAST 3'h5
`define LSC_RESP_OKAY 2'h0
`define LSC_RESP_SLVERR 2'h2
`endif

//--- src/lsc_pkg.sv
package lsc_pkg;
    typedef enum logic [4:0] {
        LSC_T_NORMAL = 5'h00, LSC_T_PRBS7 = 5'h01, LSC_T_PRBS15 = 5'h02,
        LSC_T_PRBS23 = 5'h03, LSC_T_RAMP = 5'h04, LSC_T_TRANSPORT = 5'h05,
        LSC_T_D21_5 = 5'h06, LSC_T_K28_5 = 5'h07, LSC_T_ILA = 5'h08,
        LSC_T_RPAT = 5'h09, LSC_T_LOW = 5'h0A, LSC_T_HIGH = 5'h0B,
        LSC_T_PRBS9 = 5'h0D, LSC_T_PRBS31 = 5'h0E, LSC_T_CLOCK = 5'h0F,
        LSC_T_K28_7 = 5'h10
    } lsc_test_t;
    typedef enum logic [1:0] {
        LSC_S_PIN = 2'h0, LSC_S_TSTAMP = 2'h1, LSC_S_SOFT = 2'h2, LSC_S_RSVD = 2'h3
    } lsc_sync_src_t;
    typedef enum logic [2:0] {
        LSC_P7 = 3'h0, LSC_P9 = 3'h1, LSC_P15 = 3'h2, LSC_P23 = 3'h3, LSC_P31 = 3'h4
    } lsc_prbs_t;
endpackage : lsc_pkg

//--- src/lsc_prbs.sv
`timescale 1ns/1ps
module lsc_prbs #(
    parameter int W = 16,
    parameter logic [30:0] SEED = 31'h0000_0001
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, low
    input wire logic restart, // Reload seed
    input wire logic step, // Advance one word
    input wire lsc_pkg::lsc_prbs_t poly, // Polynomial
    output logic [W-1:0] dout // Pattern word
);
    logic [30:0] state_q;
    logic [30:0] state_d;
    logic [W-1:0] word_d;

    always_comb begin
        logic fb;
        fb = 1'b0;
        state_d = state_q;
        word_d = '0;
        for (int i = W - 1; i >= 0; i--) begin
            unique case (poly)
                lsc_pkg::LSC_P7: fb = state_d[6] ^ state_d[5];
                lsc_pkg::LSC_P9: fb = state_d[8] ^ state_d[4];
                lsc_pkg::LSC_P15: fb = state_d[14] ^ state_d[13];
                lsc_pkg::LSC_P23: fb = state_d[22] ^ state_d[17];
                default: fb = state_d[30] ^ state_d[27];
            endcase
            state_d = {state_d[29:0], fb};
            word_d[i] = fb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            state_q <= SEED;
            dout <= '0;
        end else if (step) begin
            state_q <= state_d;
            dout <= word_d;
        end
    end
endmodule : lsc_prbs

//--- src/lsc_top.sv
// Functional notes
// RULE_01 - Upper mapping clear: link occupies lanes 0 to L-1.
// RULE_02 - Upper mapping set: link on lanes 4 to 4+L-1, lanes 0-3 idle.
// RULE_03 - Software uses upper mapping only for modes with four lanes or fewer.
// RULE_04 - Sync source 0: sync request comes from the single-ended pin.
// RULE_05 - Sync source 1: timestamp input, its receiver enabled by software.
// RULE_06 - Sync source 2: pins ignored, software request bit only.
// RULE_07 - Format bit 0 offset binary, 1 two's complement; resets to 1.
// RULE_08 - 8B/10B: whitening follows its enable bit, which resets to 1.
// RULE_09 - 64B/66B: whitening always on, enable bit ignored.
// RULE_10 - Software should keep 8B/10B whitening enabled.
// RULE_11 - Software changes control and test registers only while disabled.
// RULE_12 - Software writes zero into reserved bits 7:5.
// RULE_13 - Test code 0 sends normal link data; reset value.
// RULE_14 - Codes 1, 2, 3 send PRBS7, PRBS15, PRBS23.
// RULE_15 - Codes 13 and 14 send PRBS9 and PRBS31.
// RULE_16 - Code 4 sends a ramp, code 5 the transport layer pattern.
// RULE_17 - Code 6 repeats D21.5, code 7 repeats K28.5 on every lane.
// RULE_18 - Code 8 repeats the alignment sequence, code 9 modified RPAT.
// RULE_19 - Code 10 holds outputs low, code 11 holds them high.
// RULE_20 - Code 15 sends the clock pattern 0x00FF.
// RULE_21 - Code 16 repeats K28.7; codes 12 and 17-31 are reserved.
// RULE_22 - K-character, alignment and RPAT tests only in 8B/10B modes; the code also sends them when 64B/66B is selected.
// RULE_23 - Subsystem disabled: link logic reset, serializers off, clocks gated.
// RULE_24 - Software sync bit at 0 requests synchronization like the pin.
// RULE_25 - Reserved sync source 3 behaves as source 2.
// RULE_26 - PRBS restarts from nonzero seed on enable, one per lane.
`timescale 1ns/1ps
`include "lsc_regs.svh"
module lsc_top #(
    parameter int LANES = 8,
    parameter int W = 16,
    parameter int SW = 12
) (
    input wire logic aclk, // Clock, 25 MHz
    input wire logic aresetn, // Sync reset, low
    input wire logic [13:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [13:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [3:0] lane_count, // Lanes L of current mode
    input wire logic [LANES*W-1:0] link_data_in, // Normal lane words
    input wire logic [LANES*W/8-1:0] link_k_in, // Normal control flags
    input wire logic [SW-1:0] sample_in, // Two's complement sample
    input wire logic single_ended_sync_pin, // Sync pin, low requests
    input wire logic differential_timestamp_pin, // Timestamp pin level
    output logic [LANES*W-1:0] lane_data, // Lane words out
    output logic [LANES*W/8-1:0] lane_k, // Control flags out
    output logic [LANES-1:0] lane_active, // Physical lane in use
    output logic [SW-1:0] sample_out, // Formatted sample
    output logic link_sync_n, // Sync request to link, low
    output logic link_reset, // Link and multiframe reset
    output logic serializer_power_down, // Serializers off
    output logic serializer_clock_enable, // Serializer clock gate
    output logic whitening_active, // Scrambler on
    output logic timestamp_receiver_enable // Timestamp receiver on
);
    localparam int KB = W / 8;

    logic link_subsystem_enable_q;
    logic software_sync_request_n_q;
    logic [7:0] link_control_q;
    logic [7:0] link_test_select_q;
    logic [1:0] link_aux_q;
    logic aw_hold_q, w_hold_q;
    logic [11:0] aw_idx_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic [7:0] ramp_q;
    logic [1:0] ila_q;
    logic [2:0] rpat_q;
    logic upper;
    lsc_pkg::lsc_test_t test_sel;
    lsc_pkg::lsc_sync_src_t sync_src;
    lsc_pkg::lsc_prbs_t poly;

    assign upper = link_control_q[`LSC_CTRL_UPPER];
    assign test_sel = lsc_pkg::lsc_test_t'(link_test_select_q[`LSC_TEST_HI:0]);
    assign sync_src = lsc_pkg::lsc_sync_src_t'(link_control_q[`LSC_CTRL_SYNC_HI:`LSC_CTRL_SYNC_LO]);

    // ==========================================
    // AXI4-Lite write path
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

    always_comb begin
        wr_hit = 1'b1;
        unique case (aw_idx_q)
            `LSC_IDX_SUBSYS_EN, `LSC_IDX_SYNC_REQ, `LSC_IDX_LINK_CONTROL,
            `LSC_IDX_LINK_TEST_SELECT, `LSC_IDX_LINK_AUX: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_idx_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LSC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[13:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_hold_q && w_hold_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Register file; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_subsystem_enable_q <= `LSC_RST_SUBSYS_EN;
            software_sync_request_n_q <= `LSC_RST_SYNC_REQ;
            link_control_q <= `LSC_RST_LINK_CONTROL;
            link_test_select_q <= `LSC_RST_LINK_TEST_SELECT;
            link_aux_q <= `LSC_RST_LINK_AUX;
        end else if (aw_hold_q && w_hold_q && w_strb_q[0]) begin
            unique case (aw_idx_q)
                `LSC_IDX_SUBSYS_EN: link_subsystem_enable_q <= w_data_q[0];
                `LSC_IDX_SYNC_REQ: software_sync_request_n_q <= w_data_q[0]; // [RULE_24]
                // Taken whenever written; changing these live is a software fault
                `LSC_IDX_LINK_CONTROL: link_control_q <= w_data_q[7:0];
                `LSC_IDX_LINK_TEST_SELECT: link_test_select_q <= w_data_q[7:0];
                `LSC_IDX_LINK_AUX: link_aux_q <= w_data_q[1:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // AXI4-Lite read path
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_hit = 1'b1;
        rd_word = '0;
        unique case (s_axi_araddr[13:2])
            `LSC_IDX_SUBSYS_EN: rd_word[0] = link_subsystem_enable_q;
            `LSC_IDX_SYNC_REQ: rd_word[0] = software_sync_request_n_q;
            `LSC_IDX_LINK_CONTROL: rd_word[7:0] = link_control_q;
            `LSC_IDX_LINK_TEST_SELECT: rd_word[7:0] = link_test_select_q;
            `LSC_IDX_LINK_AUX: rd_word[1:0] = link_aux_q;
            `LSC_IDX_LINK_STATUS: rd_word[3:0] = {link_reset, whitening_active,
                                                   serializer_power_down, link_sync_n};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `LSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================
    // Link control outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_reset <= 1'b1;
            serializer_power_down <= 1'b1;
            serializer_clock_enable <= 1'b0;
        end else begin
            link_reset <= !link_subsystem_enable_q; // [RULE_23]
            serializer_power_down <= !link_subsystem_enable_q; // [RULE_23]
            serializer_clock_enable <= link_subsystem_enable_q; // [RULE_23]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_sync_n <= 1'b1;
        end else begin
            unique case (sync_src)
                lsc_pkg::LSC_S_PIN:
                    link_sync_n <= software_sync_request_n_q && single_ended_sync_pin; // [RULE_04]
                // Receiver off leaves the pin floating, so it reads as no request
                lsc_pkg::LSC_S_TSTAMP:
                    link_sync_n <= software_sync_request_n_q &&
                        (!link_aux_q[`LSC_AUX_TS_RX_EN] || differential_timestamp_pin); // [RULE_05]
                lsc_pkg::LSC_S_SOFT: link_sync_n <= software_sync_request_n_q; // [RULE_06]
                lsc_pkg::LSC_S_RSVD: link_sync_n <= software_sync_request_n_q; // [RULE_25]
            endcase
        end
    end

    assign timestamp_receiver_enable = link_aux_q[`LSC_AUX_TS_RX_EN];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            whitening_active <= 1'b1;
            sample_out <= '0;
        end else begin
            whitening_active <= link_aux_q[`LSC_AUX_ENC64] ||
                link_control_q[`LSC_CTRL_WHITEN]; // [RULE_08] [RULE_09]
            sample_out <= link_control_q[`LSC_CTRL_FORMAT] ? sample_in :
                {~sample_in[SW-1], sample_in[SW-2:0]}; // [RULE_07]
        end
    end

    // ==========================================
    // Shared pattern sequencers
    always_ff @(posedge aclk) begin
        if (!aresetn || !link_subsystem_enable_q) begin
            ramp_q <= '0;
            ila_q <= '0;
            rpat_q <= '0;
        end else begin
            ramp_q <= ramp_q + 8'h02;
            ila_q <= ila_q + 2'h1;
            rpat_q <= (rpat_q == `LSC_RPAT_LAST) ? 3'h0 : rpat_q + 3'h1;
        end
    end

    always_comb begin
        unique case (test_sel)
            lsc_pkg::LSC_T_PRBS7: poly = lsc_pkg::LSC_P7;
            lsc_pkg::LSC_T_PRBS9: poly = lsc_pkg::LSC_P9;
            lsc_pkg::LSC_T_PRBS15: poly = lsc_pkg::LSC_P15;
            lsc_pkg::LSC_T_PRBS23: poly = lsc_pkg::LSC_P23;
            default: poly = lsc_pkg::LSC_P31;
        endcase
    end

    function automatic logic [15:0] rpat_word(input logic [2:0] idx);
        unique case (idx)
            3'h0: rpat_word = 16'hBED7;
            3'h1: rpat_word = 16'h2347;
            3'h2: rpat_word = 16'h6B8F;
            3'h3: rpat_word = 16'hB314;
            3'h4: rpat_word = 16'h5EFB;
            default: rpat_word = 16'h3559;
        endcase
    endfunction : rpat_word

    // ==========================================
    // Per physical lane pattern selection
    for (genvar p = 0; p < LANES; p++) begin : g_lane
        localparam int SRC_HI = (p >= `LSC_UPPER_BASE) ? p - `LSC_UPPER_BASE : 0;
        logic [W-1:0] prbs_word;
        logic [W-1:0] word_d;
        logic [KB-1:0] k_d;
        logic on_d;

        lsc_prbs #(
            .W(W),
            .SEED(31'(p) + 31'h0000_0001)
        ) u_prbs (
            .aclk(aclk),
            .aresetn(aresetn),
            .restart(!link_subsystem_enable_q), // [RULE_26]
            .step(1'b1),
            .poly(poly),
            .dout(prbs_word)
        );

        always_comb begin
            if (upper) begin
                on_d = (p >= `LSC_UPPER_BASE) && (SRC_HI < int'(lane_count)); // [RULE_02]
            end else begin
                on_d = p < int'(lane_count); // [RULE_01]
            end
            on_d = on_d && link_subsystem_enable_q;
            word_d = '0;
            k_d = '0;
            unique case (test_sel)
                lsc_pkg::LSC_T_PRBS7, lsc_pkg::LSC_T_PRBS15, lsc_pkg::LSC_T_PRBS23,
                lsc_pkg::LSC_T_PRBS9, lsc_pkg::LSC_T_PRBS31:
                    word_d = prbs_word; // [RULE_14] [RULE_15]
                lsc_pkg::LSC_T_RAMP: word_d = W'({ramp_q + 8'h01, ramp_q}); // [RULE_16]
                lsc_pkg::LSC_T_TRANSPORT: word_d = W'({4'(p), 4'hA, ramp_q}); // [RULE_16]
                lsc_pkg::LSC_T_D21_5: word_d = {KB{`LSC_CHAR_D21_5}}; // [RULE_17]
                lsc_pkg::LSC_T_K28_5: begin
                    word_d = {KB{`LSC_CHAR_K28_5}}; // [RULE_17]
                    k_d = '1;
                end
                lsc_pkg::LSC_T_ILA: begin
                    word_d = W'({ramp_q, (ila_q == `LSC_ILA_LAST) ? `LSC_CHAR_K28_3 :
                        (ila_q == 2'h0) ? `LSC_CHAR_K28_0 : ramp_q}); // [RULE_18]
                    k_d[0] = (ila_q == `LSC_ILA_LAST) || (ila_q == 2'h0);
                end
                lsc_pkg::LSC_T_RPAT: word_d = W'(rpat_word(rpat_q)); // [RULE_18]
                lsc_pkg::LSC_T_LOW: word_d = '0; // [RULE_19]
                lsc_pkg::LSC_T_HIGH: word_d = '1; // [RULE_19]
                lsc_pkg::LSC_T_CLOCK: word_d = W'(`LSC_CLOCK_WORD); // [RULE_20]
                lsc_pkg::LSC_T_K28_7: begin
                    word_d = {KB{`LSC_CHAR_K28_7}}; // [RULE_21]
                    k_d = '1;
                end
                lsc_pkg::LSC_T_NORMAL: begin
                    if (upper) begin
                        word_d = link_data_in[SRC_HI*W +: W];
                        k_d = link_k_in[SRC_HI*KB +: KB];
                    end else begin
                        word_d = link_data_in[p*W +: W]; // [RULE_13]
                        k_d = link_k_in[p*KB +: KB];
                    end
                end
                // Reserved codes send idle zero words
                default: word_d = '0;
            endcase
            // Static high drives every pin; all other codes only the used lanes
            if (!(on_d || (link_subsystem_enable_q && test_sel == lsc_pkg::LSC_T_HIGH))) begin
                word_d = '0;
                k_d = '0;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                lane_data[p*W +: W] <= '0;
                lane_k[p*KB +: KB] <= '0;
                lane_active[p] <= 1'b0;
            end else begin
                lane_data[p*W +: W] <= word_d;
                lane_k[p*KB +: KB] <= k_d;
                lane_active[p] <= on_d;
            end
        end
    end

    // ==========================================
    // Checks
    sequence s_held_low;
        link_subsystem_enable_q && test_sel == lsc_pkg::LSC_T_LOW ##1
        link_subsystem_enable_q && test_sel == lsc_pkg::LSC_T_LOW;
    endsequence

    sequence s_k28_5_lane0;
        link_subsystem_enable_q && !upper && lane_count != 4'h0 &&
        test_sel == lsc_pkg::LSC_T_K28_5;
    endsequence

    a_disable_holds: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_23]
        !link_subsystem_enable_q |=> link_reset && !serializer_clock_enable && lane_active == '0)
        else $error("disabled link not held in reset");
    a_sync_soft_only: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
        sync_src[1] |=> link_sync_n == $past(software_sync_request_n_q))
        else $error("sync not from software bit");
    a_sync_from_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
        sync_src == lsc_pkg::LSC_S_PIN && !single_ended_sync_pin |=> !link_sync_n)
        else $error("sync pin request lost");
    a_whiten_64b66b: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
        link_aux_q[`LSC_AUX_ENC64] |=> whitening_active)
        else $error("64b66b whitening off");
    a_outputs_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_19]
        s_held_low |=> lane_data == '0 && lane_k == '0)
        else $error("static low not held");
    a_k28_5_fill: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
        s_k28_5_lane0 |=> lane_data[7:0] == `LSC_CHAR_K28_5 && lane_k[0])
        else $error("K28.5 not repeated");
    a_upper_unused: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
        upper |=> lane_active[`LSC_UPPER_BASE-1:0] == '0)
        else $error("lower lanes used in upper mapping");
    a_format_flip: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
        !link_control_q[`LSC_CTRL_FORMAT] |=>
        sample_out[SW-1] != $past(sample_in[SW-1]) &&
        sample_out[SW-2:0] == $past(sample_in[SW-2:0]))
        else $error("offset binary not applied");
endmodule : lsc_top

//--- dv/lsc_rx_model.sv
`timescale 1ns/1ps
// ====
// Far-end receiver: raises sync requests on the two pins
module lsc_rx_model (
    input wire logic aclk, // Clock
    input wire logic want_pin, // Request sync on the pin
    input wire logic want_ts, // Request sync on the timestamp
    output logic single_ended_sync_pin, // Low requests sync
    output logic differential_timestamp_pin // Low requests sync
);
    // Pins only move after an edge, like a clocked receiver; one driver each
    always @(posedge aclk) begin
        single_ended_sync_pin <= !want_pin;
        differential_timestamp_pin <= !want_ts;
    end
endmodule : lsc_rx_model

//--- dv/serial_link_control_and_test_tb_top.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
module serial_link_control_and_test_tb_top;
logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
logic s_axi_arvalid = '0, s_axi_rready = '0, want_pin = '0, want_ts = '0;
logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'hF, lane_count = 4'h2;
logic [127:0] link_data_in = '0, lane_data;
logic [15:0] link_k_in = '0, lane_k;
logic [11:0] sample_in = '0, sample_out;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, link_sync_n;
logic link_reset, serializer_power_down, serializer_clock_enable, whitening_active;
logic timestamp_receiver_enable, single_ended_sync_pin, differential_timestamp_pin;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [7:0] lane_active;
logic [4:0] tcode [6] = '{5'h06, 5'h07, 5'h0A, 5'h0B, 5'h0F, 5'h10};
logic [15:0] tword [6] = '{16'hB5B5, 16'hBCBC, 16'h0000, 16'hFFFF, 16'h00FF, 16'hFCFC};
logic [4:0] pcode [5] = '{5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E};
integer seed = 37185, bad_count = 0, num_checks = 0;
lsc_top dut (.*);
lsc_rx_model rx (.*);
initial forever #20 aclk = ~aclk;
// ====
// Bus and compare tasks
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
        bad_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
endtask : chk
task automatic wr(input logic [11:0] i, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, `LSC_RESP_OKAY);
    s_axi_bready <= 1'h0;
endtask : wr
task automatic rd(input logic [11:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
endtask : rd
// Outputs are registered once, pins once more in the receiver
task automatic settle;
    repeat (3) @(posedge aclk);
endtask : settle
task automatic cfg(input logic [31:0] c, input logic [31:0] t);
    wr(`LSC_IDX_SUBSYS_EN, 32'h0);
    wr(`LSC_IDX_LINK_CONTROL, c);
    wr(`LSC_IDX_LINK_TEST_SELECT, t);
    wr(`LSC_IDX_SUBSYS_EN, 32'h1);
    settle;
endtask : cfg
function automatic logic exp_sync(logic [1:0] s, logic sw, logic p, logic t, logic en);
    case (s)
        2'h0: return sw & p;
        2'h1: return sw & (!en | t);
        default: return sw;
    endcase
endfunction : exp_sync
function automatic logic [7:0] exp_act(logic u, logic [3:0] l);
    for (int p = 0; p < 8; p++) exp_act[p] = u ? (p >= 4 && p - 4 < l) : (p < l);
endfunction : exp_act
task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask : finish_test
initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    finish_test;
end
// ====
// Main sequence
initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] w;
    int n;
    logic [31:0] s;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`LSC_IDX_LINK_CONTROL, d, r);
    chk(d, 32'h03);
    rd(`LSC_IDX_LINK_TEST_SELECT, d, r);
    chk(d, 32'h00);
    rd(12'h3FF, d, r);
    chk(r, `LSC_RESP_SLVERR);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
        cfg({k[1:0], 2'h3}, 32'h0);
        repeat (4) begin
            d = $random(seed);
            wr(`LSC_IDX_SYNC_REQ, {31'h0, d[0]});
            wr(`LSC_IDX_LINK_AUX, {30'h0, d[1], 1'h0});
            want_pin <= d[2];
            want_ts <= d[3];
            settle;
            s = exp_sync(k[1:0], d[0], !d[2], !d[3], d[1]);
            chk(link_sync_n, s);
            chk(timestamp_receiver_enable, d[1]);
        end
    end
    $display("sync test done");
    for (int k = 0; k < 8; k++) begin
        wr(`LSC_IDX_LINK_AUX, {31'h0, k[2]});
        cfg(k[1:0], 32'h0);
        sample_in <= 12'($random(seed));
        settle;
        chk(sample_out, k[1] ? sample_in : sample_in ^ 12'h800);
        chk(whitening_active, k[2] | k[0]);
    end
    $display("format test done");
    wr(`LSC_IDX_LINK_AUX, 32'h0);
    for (int k = 0; k < 6; k++) begin
        d = $random(seed);
        lane_count <= {2'h0, d[1:0]} + 4'h1;
        cfg({k[0], 4'h3}, tcode[k]);
        chk(lane_active, exp_act(k[0], lane_count));
        chk(lane_data[k[0]*64 +: 16], tword[k]);
        // Only the K-character codes flag control bytes
        s = {2{tcode[k] == 5'h07 || tcode[k] == 5'h10}};
        chk(lane_k[k[0]*8 +: 2], s);
    end
    link_data_in <= {4{$random(seed)}};
    link_k_in <= 16'($random(seed));
    cfg(32'h3, 32'h0);
    chk(lane_data[15:0], link_data_in[15:0]);
    chk(lane_k[1:0], link_k_in[1:0]);
    cfg(32'h13, 32'h0);
    chk(lane_data[79:64], link_data_in[15:0]);
    chk(lane_k[9:8], link_k_in[1:0]);
    for (int k = 0; k < 5; k++) begin
        cfg(32'h3, pcode[k]);
        w = lane_data[15:0];
        @(posedge aclk);
        chk(w != 16'h0 && w !== lane_data[15:0], 1'h1);
    end
    cfg(32'h3, 32'h4);
    w = lane_data[15:0];
    @(posedge aclk);
    chk(lane_data[15:0], {w[7:0] + 8'h3, w[7:0] + 8'h2});
    cfg(32'h3, 32'h5);
    chk(lane_data[15:8], 8'h0A);
    // Any four consecutive alignment words hold K28.0 and K28.3 once each
    cfg(32'h3, 32'h8);
    n = 0;
    s = '0;
    repeat (4) begin
        @(posedge aclk);
        n += lane_k[0];
        if (lane_k[0]) s += lane_data[7:0];
    end
    chk(n, 2);
    chk(s, 32'h98);
    // Phase-free check: any six consecutive RPAT words sum to the same total
    cfg(32'h3, 32'h9);
    s = '0;
    repeat (6) begin
        @(posedge aclk);
        s += lane_data[15:0];
    end
    chk(s, 32'h29515);
    $display("pattern test done");
    wr(`LSC_IDX_SUBSYS_EN, 32'h0);
    settle;
    chk({link_reset, serializer_power_down, serializer_clock_enable, lane_active},
        11'h600);
    $display("disable test done");
    finish_test;
end
endmodule : serial_link_control_and_test_tb_top
